//--- logic/flash_page_decode_protect_map.sv
module flash_page_decode_protect_map (
	input  wire logic        i_mclk,
	input  wire logic        i_reset,
	input  wire logic        i_valid,
	input  wire logic [15:0] i_addr,
	input  wire logic [7:0]  i_page_select_value,
	input  wire logic        i_low_map_allow,
	input  wire logic        i_rd_valid,
	input  wire logic [7:0]  i_rd_data,
	output logic             o_rd_req,
	output logic [16:0]      o_rd_addr,
	output logic             o_ready,
	output logic             o_hit,
	output logic [16:0]      o_arr_addr,
	output logic             o_protected,
	output logic             o_in_low,
	output logic             o_in_high,
	output logic             o_key_hit,
	output logic             o_prot_hit,
	output logic             o_sec_hit,
	output logic [7:0]       o_protection_setting_register,
	output logic [7:0]       o_security_setting_register
);
	// =====================================================
	// Reset sequence: fetch config bytes
	// =====================================================
	typedef enum logic [1:0] {LD_PROT, LD_SEC, LD_DONE} load_e;
	load_e       st_q, st_d;
	logic        req_q, req_d;
	logic [16:0] ra_q, ra_d;
	logic        ld_prot, ld_sec;
	logic [7:0]  prot_val, sec_val;

	always_comb begin
		st_d    = st_q;
		req_d   = 1'b0;
		ra_d    = ra_q;
		ld_prot = 1'b0;
		ld_sec  = 1'b0;
		unique case (st_q)
			LD_PROT: begin
				req_d = ~i_rd_valid;
				ra_d  = flash_map_pkg::ARR_PROT_BYTE;
				if (i_rd_valid) begin
					ld_prot = 1'b1;
					st_d    = LD_SEC;
					ra_d    = flash_map_pkg::ARR_SEC_BYTE;
					req_d   = 1'b1;
				end
			end
			LD_SEC: begin
				req_d = ~i_rd_valid;
				if (i_rd_valid) begin
					ld_sec = 1'b1;
					st_d   = LD_DONE;
				end
			end
			LD_DONE: begin
				req_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			st_q  <= LD_PROT;
			req_q <= 1'b0;
			ra_q  <= flash_map_pkg::ARR_PROT_BYTE;
		end else begin
			st_q  <= st_d;
			req_q <= req_d;
			ra_q  <= ra_d;
		end
	end

	flash_cfg_latch #(
		.WIDTH     (8),
		.RESET_VAL (flash_map_pkg::PROT_RESET)
	) u_prot (
		.i_mclk  (i_mclk),
		.i_reset (i_reset),
		.i_load  (ld_prot),
		.i_data  (i_rd_data),
		.o_value (prot_val)
	);

	flash_cfg_latch #(
		.WIDTH     (8),
		.RESET_VAL (flash_map_pkg::SEC_RESET)
	) u_sec (
		.i_mclk  (i_mclk),
		.i_reset (i_reset),
		.i_load  (ld_sec),
		.i_data  (i_rd_data),
		.o_value (sec_val)
	);

	// =====================================================
	// Address decode
	// =====================================================
	flash_map_pkg::decode_s dec;
	logic [7:0]  page;
	logic [1:0]  win;

	always_comb begin
		win  = i_addr[15:14];
		page = 8'h00;
		dec  = '0;
		unique case (win)
			flash_map_pkg::WIN_UNPAGED: begin
				page    = flash_map_pkg::PAGE_UNPAGED;
				dec.hit = i_low_map_allow;
			end
			flash_map_pkg::WIN_LOW: begin
				page    = flash_map_pkg::PAGE_LOW_FIXED;
				dec.hit = 1'b1;
			end
			flash_map_pkg::WIN_MID: begin
				page    = i_page_select_value;
				// Only 0x3C..0x3F belong to this array
				dec.hit = (i_page_select_value[7:2]
					== flash_map_pkg::PAGE_FIRST[7:2]);
			end
			flash_map_pkg::WIN_HIGH: begin
				page    = flash_map_pkg::PAGE_HIGH_FIX;
				dec.hit = 1'b1;
			end
		endcase
		// Page 0x3C sits at 0x10000; 0x3E/0x3F alias fixed pages
		dec.arr_addr = {1'b1, page[1:0], i_addr[13:0]};
		dec.key_hit  = dec.hit && win == flash_map_pkg::WIN_HIGH
			&& i_addr >= flash_map_pkg::KEY_FIRST
			&& i_addr <= flash_map_pkg::KEY_LAST;
		dec.prot_hit = dec.hit
			&& dec.arr_addr == flash_map_pkg::ARR_PROT_BYTE;
		dec.sec_hit  = dec.hit
			&& dec.arr_addr == flash_map_pkg::ARR_SEC_BYTE;
	end

	// =====================================================
	// Protection regions
	// =====================================================
	flash_map_pkg::region_s reg_r;
	logic [16:0] low_size, high_size, low_end, high_start;

	always_comb begin
		low_size   = flash_map_pkg::LOW_1K
			<< prot_val[flash_map_pkg::PROT_LS_LSB +: 2];
		high_size  = flash_map_pkg::HIGH_2K
			<< prot_val[flash_map_pkg::PROT_HS_LSB +: 2];
		low_end    = 17'(flash_map_pkg::LOW_BASE + low_size);
		high_start = 17'(flash_map_pkg::ARRAY_TOP - high_size + 17'h0_0001);
		reg_r.in_low  = dec.arr_addr >= flash_map_pkg::LOW_BASE
			&& dec.arr_addr < low_end;
		reg_r.in_high = dec.arr_addr >= high_start;
		reg_r.in_rest = ~reg_r.in_low & ~reg_r.in_high;
		// Open bit clear: whole array locked
		if (!prot_val[flash_map_pkg::PROT_OPEN]) begin
			reg_r.locked = 1'b1;
		end else begin
			// Rest follows any enabled region, so low can stay open
			reg_r.locked =
				(reg_r.in_low & ~prot_val[flash_map_pkg::PROT_LDIS])
				| (reg_r.in_high & ~prot_val[flash_map_pkg::PROT_HDIS])
				| (reg_r.in_rest & ~(prot_val[flash_map_pkg::PROT_LDIS]
				& prot_val[flash_map_pkg::PROT_HDIS]));
		end
	end

	// =====================================================
	// Registered outputs, one cycle after request
	// =====================================================
	logic                   hit_q, prot_q, low_q, high_q;
	logic                   key_q, pb_q, sb_q, rdy_q;
	logic [16:0]            aa_q;
	logic [7:0]             protr_q, secr_q;

	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			hit_q   <= 1'b0;
			prot_q  <= 1'b0;
			low_q   <= 1'b0;
			high_q  <= 1'b0;
			key_q   <= 1'b0;
			pb_q    <= 1'b0;
			sb_q    <= 1'b0;
			rdy_q   <= 1'b0;
			aa_q    <= 17'h0_0000;
			protr_q <= flash_map_pkg::PROT_RESET;
			secr_q  <= flash_map_pkg::SEC_RESET;
		end else begin
			hit_q   <= i_valid & dec.hit;
			prot_q  <= i_valid & dec.hit & reg_r.locked;
			low_q   <= i_valid & dec.hit & reg_r.in_low;
			high_q  <= i_valid & dec.hit & reg_r.in_high;
			key_q   <= i_valid & dec.key_hit;
			pb_q    <= i_valid & dec.prot_hit;
			sb_q    <= i_valid & dec.sec_hit;
			// Ready waits one edge so it rises with the setting copies
			rdy_q   <= (st_q == LD_DONE);
			aa_q    <= dec.arr_addr;
			protr_q <= prot_val;
			secr_q  <= sec_val;
		end
	end

	// Internal bus only, nothing goes off chip
	assign o_rd_req    = req_q;
	assign o_rd_addr   = ra_q;
	assign o_ready     = rdy_q;
	assign o_hit       = hit_q;
	assign o_arr_addr  = aa_q;
	assign o_protected = prot_q;
	assign o_in_low    = low_q;
	assign o_in_high   = high_q;
	assign o_key_hit   = key_q;
	assign o_prot_hit  = pb_q;
	assign o_sec_hit   = sb_q;
	assign o_protection_setting_register = protr_q;
	assign o_security_setting_register   = secr_q;

	// =====================================================
	// Checks
	// =====================================================
	a_fixed_high_page: assert property (@(posedge i_mclk) disable iff (i_reset)
		i_valid && i_addr[15:14] == 2'h3 |=> o_hit
		&& o_arr_addr[16:14] == 3'h7) else $error("high page map");
	a_mid_page_sel: assert property (@(posedge i_mclk) disable iff (i_reset)
		i_valid && i_addr[15:14] == 2'h2 && i_page_select_value == 8'h3C
		|=> o_hit && o_arr_addr[16:14] == 3'h4) else $error("page 3C");
	a_mid_page_miss: assert property (@(posedge i_mclk) disable iff (i_reset)
		i_valid && i_addr[15:14] == 2'h2 && i_page_select_value == 8'h20
		|=> !o_hit) else $error("foreign page hit");
	a_low_map_gate: assert property (@(posedge i_mclk) disable iff (i_reset)
		i_valid && i_addr[15:14] == 2'h0
		|=> o_hit == $past(i_low_map_allow)) else $error("low gate");
	a_key_range: assert property (@(posedge i_mclk) disable iff (i_reset)
		i_valid && i_addr == 16'hFF07 |=> o_key_hit
		&& !o_sec_hit) else $error("key range");
	a_sec_byte: assert property (@(posedge i_mclk) disable iff (i_reset)
		i_valid && i_addr == 16'hFF0F |=> o_sec_hit) else $error("sec");
	a_sec_load: assert property (@(posedge i_mclk) disable iff (i_reset)
		st_q == LD_SEC && i_rd_valid |-> ##2
		o_security_setting_register == $past(i_rd_data, 2))
		else $error("sec load");
	a_global_lock: assert property (@(posedge i_mclk) disable iff (i_reset)
		i_valid && dec.hit && !prot_val[7] |=> o_protected)
		else $error("global lock");
endmodule : flash_page_decode_protect_map

//--- logic/flash_map_pkg.sv
// Operation
// - Logical 0x4000..0xFFFF decode to the flash array as three 16K pages.
// - Middle window 0x8000..0xBFFF takes its physical page from page select.
// - Page select 0x3C..0x3F picks array pages 0x10000 upward in 16K steps.
// - Fixed low window is page 0x3E, fixed high window is page 0x3F.
// - Protection setting can protect the whole array against program/erase.
// - Lower and higher areas are protectable independently; the remaining area is protected whenever either one is.
// - Lower area may stay open while all else is protected.
// - Backdoor key occupies flash addresses 0xFF00..0xFF07.
// - Byte 0xFF0D holds the default protection setting.
// - Byte 0xFF0F holds the security and options setting.
// - Every reset loads the security register from byte 0xFF0F.
// - No signals leave the chip; all traffic uses the internal bus.
package flash_map_pkg;
	localparam logic [15:0] LOG_LOW_START  = 16'h4000;
	localparam logic [1:0]  WIN_UNPAGED    = 2'h0;
	localparam logic [1:0]  WIN_LOW        = 2'h1;
	localparam logic [1:0]  WIN_MID        = 2'h2;
	localparam logic [1:0]  WIN_HIGH       = 2'h3;
	localparam logic [7:0]  PAGE_FIRST     = 8'h3C;
	localparam logic [7:0]  PAGE_UNPAGED   = 8'h3D;
	localparam logic [7:0]  PAGE_LOW_FIXED = 8'h3E;
	localparam logic [7:0]  PAGE_HIGH_FIX  = 8'h3F;
	localparam logic [5:0]  PAGE_HI_BITS   = 6'h0F;
	localparam logic [16:0] ARRAY_BASE     = 17'h1_0000;
	localparam logic [15:0] KEY_FIRST      = 16'hFF00;
	localparam logic [15:0] KEY_LAST       = 16'hFF07;
	localparam logic [15:0] PROT_BYTE_ADDR = 16'hFF0D;
	localparam logic [15:0] SEC_BYTE_ADDR  = 16'hFF0F;
	localparam logic [16:0] ARR_PROT_BYTE  = 17'h1_FF0D;
	localparam logic [16:0] ARR_SEC_BYTE   = 17'h1_FF0F;
	localparam logic [16:0] LOW_BASE       = 17'h1_8000;
	localparam logic [16:0] ARRAY_TOP      = 17'h1_FFFF;
	// Protection byte fields
	localparam int PROT_OPEN   = 7;
	localparam int PROT_HDIS   = 5;
	localparam int PROT_HS_LSB = 3;
	localparam int PROT_LDIS   = 2;
	localparam int PROT_LS_LSB = 0;
	localparam logic [7:0]  PROT_RESET = 8'hFF;
	localparam logic [7:0]  SEC_RESET  = 8'hFF;
	localparam logic [16:0] LOW_1K     = 17'h0_0400;
	localparam logic [16:0] HIGH_2K    = 17'h0_0800;

	typedef struct packed {
		logic        hit;
		logic [16:0] arr_addr;
		logic        key_hit;
		logic        prot_hit;
		logic        sec_hit;
	} decode_s;

	typedef struct packed {
		logic in_low;
		logic in_high;
		logic in_rest;
		logic locked;
	} region_s;
endpackage : flash_map_pkg

//--- logic/flash_cfg_latch.sv
module flash_cfg_latch #(
	parameter int WIDTH = 8,
	parameter logic [7:0] RESET_VAL = 8'hFF
) (
	input  wire logic             i_mclk,
	input  wire logic             i_reset,
	input  wire logic             i_load,
	input  wire logic [WIDTH-1:0] i_data,
	output logic      [WIDTH-1:0] o_value
);
	logic [WIDTH-1:0] value_q;
	logic [WIDTH-1:0] value_d;

	always_comb begin
		value_d = value_q;
		if (i_load) begin
			value_d = i_data;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			value_q <= RESET_VAL[WIDTH-1:0];
		end else begin
			value_q <= value_d;
		end
	end

	assign o_value = value_q;
endmodule : flash_cfg_latch

//--- bench/flash_cfg_responder.sv
module flash_cfg_responder (
	input  wire logic        i_mclk,
	input  wire logic        i_req,
	input  wire logic [16:0] i_addr,
	input  wire logic [7:0]  i_prot,
	input  wire logic [7:0]  i_sec,
	input  wire logic [3:0]  i_delay,
	output logic             o_valid,
	output logic [7:0]       o_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] wait_q;
	initial begin
		o_valid = 1'b0;
		o_data = 8'h00;
		wait_q = 4'h0;
	end
	// Idle data toggles so a stale byte is never mistaken for a fresh one
	always @(negedge i_mclk) begin
		if (o_valid) begin
			o_valid <= 1'b0;
			o_data <= ~o_data;
			wait_q <= 4'h0;
		end else if (i_req && wait_q == i_delay) begin
			o_valid <= 1'b1;
			o_data <= (i_addr === flash_map_pkg::ARR_SEC_BYTE)
				? i_sec : i_prot;
		end else begin
			o_data <= ~o_data;
			if (i_req) begin
				wait_q <= wait_q + 4'h1;
			end
		end
	end
endmodule : flash_cfg_responder

//--- bench/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 0, rst = 1, valid = 0, allow = 0;
	logic [15:0] addr = 16'h0000;
	logic [7:0]  page = 8'h00, prot = 8'hFF, sec = 8'hFF, rdat, preg, sreg;
	logic [3:0]  dly = 4'h0;
	logic        rval, rreq, ready, hit, protd, in_lo, in_hi, key, ph, sh;
	logic [16:0] raddr, arr;
	int          n_mismatch = 0, n_compared = 0, cyc = 0;

	always #5 clk = ~clk;

	flash_page_decode_protect_map flash_page_decode_protect_map_i (
		.i_mclk(clk), .i_reset(rst), .i_valid(valid), .i_addr(addr),
		.i_page_select_value(page), .i_low_map_allow(allow),
		.i_rd_valid(rval), .i_rd_data(rdat), .o_rd_req(rreq),
		.o_rd_addr(raddr), .o_ready(ready), .o_hit(hit), .o_arr_addr(arr),
		.o_protected(protd), .o_in_low(in_lo), .o_in_high(in_hi),
		.o_key_hit(key), .o_prot_hit(ph), .o_sec_hit(sh),
		.o_protection_setting_register(preg),
		.o_security_setting_register(sreg));

	flash_cfg_responder flash_cfg_responder_i (
		.i_mclk(clk), .i_req(rreq), .i_addr(raddr), .i_prot(prot),
		.i_sec(sec), .i_delay(dly), .o_valid(rval), .o_data(rdat));

	task automatic tally_and_finish();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : tally_and_finish

	task automatic check(input logic [17:0] seen, input logic [17:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// Outputs are sampled one falling edge after the taking edge
	task automatic dec(input logic [15:0] a, input logic [7:0] p,
			input logic al);
		@(negedge clk);
		valid = 1'b1;
		addr = a;
		page = p;
		allow = al;
		@(negedge clk);
		valid = 1'b0;
	endtask : dec

	task automatic do_reset(input logic [7:0] p, input logic [7:0] s,
			input logic [3:0] d);
		@(negedge clk);
		rst = 1'b1;
		prot = p;
		sec = s;
		dly = d;
		repeat (6) @(negedge clk);
		check({ready, preg, sreg}, 17'h0_FFFF);
		rst = 1'b0;
		for (int i = 0; i < 60 && ready !== 1'b1; i++)
			@(negedge clk);
		check(ready, 1'b1);
		check(preg, p);
		check(sreg, s);
	endtask : do_reset

	task automatic t_map();
		dec(16'h4000, 8'h00, 1'b0);
		check({hit, arr}, 18'h3_8000);
		dec(16'hFFFF, 8'h3C, 1'b0);
		check({hit, arr}, 18'h3_FFFF);
		for (int p = 0; p < 4; p++) begin
			dec(16'h8123, 8'h3C + 8'(p), 1'b0);
			check(arr, 17'h1_0123 + 17'(p) * 17'h0_4000);
			check(hit, 1'b1);
		end
		dec(16'h0000, 8'h3C, 1'b1);
		check({hit, arr}, 18'h3_4000);
		dec(16'h3FFF, 8'h3C, 1'b0);
		check(hit, 1'b0);
		dec(16'h8000, 8'h20, 1'b0);
		check(hit, 1'b0);
	endtask : t_map

	task automatic t_cfg();
		logic [15:0] ca [6] = '{16'hFF00, 16'hFF07, 16'hFF08, 16'hFF0D,
			16'hFF0E, 16'hFF0F};
		logic [2:0]  ce [6] = '{3'h4, 3'h4, 3'h0, 3'h2, 3'h0, 3'h1};
		for (int i = 0; i < 6; i++) begin
			dec(ca[i], 8'h3C, 1'b0);
			check({key, ph, sh}, ce[i]);
		end
	endtask : t_cfg

	task automatic t_size(input int n);
		logic [15:0] lo_end, hi_st;
		lo_end = 16'h4000 + (16'h0400 << n) - 16'h0001;
		hi_st = 16'h0000 - (16'h0800 << n);
		do_reset(8'h80 | 8'(n << 3) | 8'(n), 8'h5A, 4'(n));
		dec(lo_end, 8'h3C, 1'b0);
		check({in_lo, protd}, 2'h3);
		dec(lo_end + 16'h0001, 8'h3C, 1'b0);
		check({in_lo, protd}, 2'h1);
		dec(hi_st, 8'h3C, 1'b0);
		check({in_hi, protd}, 2'h3);
		dec(hi_st - 16'h0001, 8'h3C, 1'b0);
		check({in_hi, protd}, 2'h1);
	endtask : t_size

	task automatic t_whole();
		do_reset(8'h7F, 8'hC3, 4'h1);
		dec(16'h4000, 8'h3C, 1'b0);
		check(protd, 1'b1);
		dec(16'h8000, 8'h3C, 1'b0);
		check(protd, 1'b1);
	endtask : t_whole

	task automatic t_low_open();
		do_reset(8'h84, 8'h3C, 4'h5);
		dec(16'h4000, 8'h3C, 1'b0);
		check(protd, 1'b0);
		dec(16'hFFFF, 8'h3C, 1'b0);
		check(protd, 1'b1);
		dec(16'h8000, 8'h3C, 1'b0);
		check(protd, 1'b1);
	endtask : t_low_open

	// Whole run needs about 180 cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	initial begin
		do_reset(8'hFF, 8'hA5, 4'h0);
		t_map();
		t_cfg();
		for (int n = 0; n < 4; n++)
			t_size(n);
		t_whole();
		t_low_open();
		tally_and_finish();
	end
endmodule : testbench
